// File: rtl/mb_pkg.sv
package mb_pkg;

	// Function codes seen on the link.
	localparam logic [7:0] FC_READ    = 8'h03;
	localparam logic [7:0] FC_WR1     = 8'h06;
	localparam logic [7:0] FC_DIAG    = 8'h08;
	localparam logic [7:0] FC_WRN     = 8'h10;
	localparam logic [7:0] FC_LOG     = 8'h46;
	// Exception marking and codes.
	localparam logic [7:0] EXC_FLAG   = 8'h80;
	localparam logic [7:0] EXC_FUNC   = 8'h01;
	localparam logic [7:0] EXC_ADDR   = 8'h02;
	localparam logic [7:0] EXC_DATA   = 8'h03;
	// Broadcast slave address.
	localparam logic [7:0] BCAST_ADDR = 8'h00;
	// Largest register count in one write-multiple query.
	localparam int         MAX_REGS   = 125;
	// Frame length figures in bytes.
	localparam logic [8:0] MIN_FRAME  = 9'h004;
	localparam logic [8:0] CRC_LEN    = 9'h002;
	localparam logic [8:0] WRN_HDR    = 9'h007;
	localparam logic [8:0] WRN_FIXED  = WRN_HDR + CRC_LEN;
	localparam logic [8:0] DATA_END   = WRN_HDR + 9'(2 * MAX_REGS);
	localparam logic [8:0] LOG_QLEN   = 9'h004;
	localparam logic [8:0] LOG_BODY   = LOG_QLEN - CRC_LEN;
	// Reply lengths before the CRC.
	localparam logic [2:0] RSP_NORM   = 3'h6;
	localparam logic [2:0] RSP_EXC    = 3'h3;
	// CRC-16 seed and reflected polynomial.
	localparam logic [15:0] CRC_INIT  = 16'hffff;
	localparam logic [15:0] CRC_POLY  = 16'ha001;

	// One byte of the CRC, LSB first; a whole frame with its CRC leaves zero.
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int k = 0; k < 8; k++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : crc_step

endpackage : mb_pkg

// File: rtl/mb_link_if.sv
`timescale 1ns/1ps
// Byte stream in both directions between master and slave on one clock.
interface mb_link_if;
	logic       m2s_valid; // Master byte present.
	logic [7:0] m2s_data;  // Master byte.
	logic       m2s_last;  // Last byte of the master frame.
	logic       m2s_err;   // Line error on this byte.
	logic       s2m_valid; // Slave byte present.
	logic [7:0] s2m_data;  // Slave byte.
	logic       s2m_last;  // Last byte of the slave frame.

	modport device (input m2s_valid, m2s_data, m2s_last, m2s_err,
		output s2m_valid, s2m_data, s2m_last);
	modport master (output m2s_valid, m2s_data, m2s_last, m2s_err,
		input s2m_valid, s2m_data, s2m_last);
endinterface : mb_link_if

// File: rtl/mb_slave.sv
`timescale 1ns/1ps
// Slave end: write-multiple, access log and exception replies.
module mb_slave
	import mb_pkg::*;
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_rstn,
	mb_link_if.device        lnk,
	input  wire logic [7:0]  i_my_addr,
	output logic      [15:0] o_reg_addr,
	output logic      [15:0] o_reg_data,
	input  wire logic        i_reg_ok,
	input  wire logic        i_val_ok,
	output logic             o_wr_en,
	output logic             o_ext_frame,
	output logic      [7:0]  o_ext_fc,
	input  wire logic        i_ext_done,
	input  wire logic [7:0]  i_ext_fc,
	input  wire logic [15:0] i_ext_start,
	input  wire logic [15:0] i_ext_count,
	output logic      [15:0] o_log_start,
	output logic      [15:0] o_log_count
);

	typedef enum logic [3:0] {
		ST_RX  = 4'b0001,
		ST_CHK = 4'b0010,
		ST_WR  = 4'b0100,
		ST_TX  = 4'b1000
	} sst_t;

	sst_t        st_ff,    nxt_st;    // Main state.
	logic [8:0]  n_ff,     nxt_n;     // Byte index, receive or transmit.
	logic [15:0] crc_ff,   nxt_crc;   // Running CRC.
	logic [7:0]  hdr_ff    [7];       // Header bytes of the query.
	logic [7:0]  nxt_hdr   [7];
	logic [15:0] dat_ff    [MAX_REGS]; // Write data words.
	logic [15:0] nxt_dat   [MAX_REGS];
	logic        drop_ff,  nxt_drop;  // Frame is being discarded.
	logic [6:0]  idx_ff,   nxt_idx;   // Word index in check and write.
	logic [15:0] addr_ff,  nxt_addr;  // Register address in check and write.
	logic [15:0] nok_ff,   nxt_nok;   // Count of accessible registers.
	logic [15:0] first_ff, nxt_first; // First accessible address.
	logic        bad_ff,   nxt_bad;   // Some value was refused.
	logic [7:0]  rsp_ff    [6];       // Reply bytes before the CRC.
	logic [7:0]  nxt_rsp   [6];
	logic [2:0]  rlen_ff,  nxt_rlen;  // Reply length before the CRC.
	logic        ext_ff,   nxt_ext;   // Frame handed to outer logic.
	logic [7:0]  efc_ff,   nxt_efc;   // Its function code.
	logic [15:0] ls_ff,    nxt_ls;    // Logged start address.
	logic [15:0] lc_ff,    nxt_lc;    // Logged register count.
	logic        tv_ff,    nxt_tv;    // Transmit byte valid.
	logic [7:0]  td_ff,    nxt_td;    // Transmit byte.
	logic        tl_ff,    nxt_tl;    // Transmit last byte.

	logic [15:0] cnt, start, crc_cur, crc_in, nok_all;
	logic [8:0]  n_in, doff;
	logic [7:0]  ecode;
	logic        bcast, go_exc, go_norm, is_last, badf;

	// Query fields decoded from the stored header.
	assign cnt     = {hdr_ff[4], hdr_ff[5]};
	assign start   = {hdr_ff[2], hdr_ff[3]}; // Zero-based register index.
	assign bcast   = (hdr_ff[0] == BCAST_ADDR);
	assign crc_cur = (n_ff == 9'h000) ? CRC_INIT : crc_ff;
	assign crc_in  = crc_step(crc_cur, lnk.m2s_data);
	assign n_in    = n_ff + 9'h001;
	assign doff    = n_ff - WRN_HDR;
	assign is_last = (16'(idx_ff) == (cnt - 16'h0001));
	assign nok_all = nok_ff + 16'(i_reg_ok);
	assign badf    = bad_ff | (i_reg_ok & ~i_val_ok);

	// Next-state logic for receive, check, write and reply.
	always_comb begin
		nxt_st = st_ff; nxt_n = n_ff; nxt_crc = crc_ff; nxt_hdr = hdr_ff;
		nxt_dat = dat_ff; nxt_drop = drop_ff; nxt_idx = idx_ff; nxt_addr = addr_ff;
		nxt_nok = nok_ff; nxt_first = first_ff; nxt_bad = bad_ff; nxt_rsp = rsp_ff;
		nxt_rlen = rlen_ff; nxt_ext = 1'b0; nxt_efc = efc_ff; nxt_ls = ls_ff;
		nxt_lc = lc_ff; nxt_tv = 1'b0; nxt_td = td_ff; nxt_tl = 1'b0;
		go_exc = 1'b0; go_norm = 1'b0; ecode = EXC_DATA;
		// Bytes that arrive while busy spoil their frame.
		if (lnk.m2s_valid && st_ff != ST_RX) begin
			nxt_drop = ~lnk.m2s_last;
		end
		case (st_ff)
			ST_RX: begin
				if (lnk.m2s_valid) begin
					nxt_crc = crc_in;
					nxt_n = n_in;
					if (lnk.m2s_err) begin
						nxt_drop = 1'b1;
					end
					if (n_ff < WRN_HDR) begin
						nxt_hdr[n_ff[2:0]] = lnk.m2s_data;
					end else if (n_ff < DATA_END) begin
						// High byte then low byte of each word.
						if (!doff[0]) nxt_dat[doff[7:1]][15:8] = lnk.m2s_data;
						else nxt_dat[doff[7:1]][7:0] = lnk.m2s_data;
					end
					if (lnk.m2s_last) begin
						nxt_n = 9'h000;
						nxt_drop = 1'b0;
						// Errors, short frames and foreign addresses stay silent.
						if (!drop_ff && !lnk.m2s_err && n_in >= MIN_FRAME
							&& crc_in == 16'h0000
							&& (hdr_ff[0] == i_my_addr || bcast)) begin
							case (hdr_ff[1])
								FC_WRN: begin
									// Count and byte count must agree with the frame.
									if (cnt == 16'h0000 || cnt > 16'(MAX_REGS)
										|| {8'h00, hdr_ff[6]} != {cnt[14:0], 1'b0}
										|| n_in != {1'b0, hdr_ff[6]} + WRN_FIXED) begin
										go_exc = 1'b1;
									end else begin
										nxt_st = ST_CHK;
										nxt_idx = 7'h00;
										nxt_addr = start;
										nxt_nok = 16'h0000;
										nxt_bad = 1'b0;
									end
								end
								FC_LOG: begin
									// A broadcast log query is ignored.
									if (bcast) begin
										nxt_st = ST_RX;
									end else if (n_in != LOG_QLEN) begin
										go_exc = 1'b1;
									end else begin
										nxt_rsp[2] = ls_ff[15:8];
										nxt_rsp[3] = ls_ff[7:0];
										nxt_rsp[4] = lc_ff[15:8];
										nxt_rsp[5] = lc_ff[7:0];
										go_norm = 1'b1;
									end
								end
								FC_READ, FC_WR1, FC_DIAG: begin
									// Served by the outer logic.
									nxt_ext = 1'b1;
									nxt_efc = hdr_ff[1];
								end
								default: begin
									go_exc = 1'b1;
									ecode = EXC_FUNC;
								end
							endcase
						end
					end
				end
			end
			ST_CHK: begin
				// Visit every addressed register and count the usable ones.
				nxt_addr = addr_ff + 16'h0001;
				nxt_idx = idx_ff + 7'h01;
				nxt_nok = nok_all;
				nxt_bad = badf;
				if (i_reg_ok && nok_ff == 16'h0000) begin
					nxt_first = addr_ff;
				end
				if (is_last) begin
					if (badf) begin
						go_exc = 1'b1;
					end else if (nok_all == 16'h0000) begin
						go_exc = 1'b1;
						ecode = EXC_ADDR;
					end else begin
						nxt_st = ST_WR;
						nxt_idx = 7'h00;
						nxt_addr = start;
					end
				end
			end
			ST_WR: begin
				// One register per cycle in ascending order.
				nxt_addr = addr_ff + 16'h0001;
				nxt_idx = idx_ff + 7'h01;
				if (is_last) begin
					nxt_ls = first_ff;
					nxt_lc = nok_ff;
					nxt_rsp[2] = hdr_ff[2];
					nxt_rsp[3] = hdr_ff[3];
					nxt_rsp[4] = hdr_ff[4];
					nxt_rsp[5] = hdr_ff[5];
					go_norm = 1'b1;
				end
			end
			ST_TX: begin
				// Body bytes, then CRC low and high.
				nxt_tv = 1'b1;
				nxt_n = n_in;
				if (n_ff < {6'h00, rlen_ff}) begin
					nxt_td = rsp_ff[n_ff[2:0]];
					nxt_crc = crc_step(crc_cur, rsp_ff[n_ff[2:0]]);
				end else if (n_ff == {6'h00, rlen_ff}) begin
					nxt_td = crc_ff[7:0];
				end else begin
					nxt_td = crc_ff[15:8];
					nxt_tl = 1'b1;
					nxt_st = ST_RX;
					nxt_n = 9'h000;
				end
			end
			default: begin
				nxt_st = ST_RX;
			end
		endcase
		// Exception reply; a failed transaction clears the log.
		if (go_exc) begin
			nxt_ls = 16'h0000;
			nxt_lc = 16'h0000;
			nxt_st = ST_RX;
			nxt_rsp[1] = hdr_ff[1] | EXC_FLAG;
			nxt_rsp[2] = ecode;
			nxt_rlen = RSP_EXC;
		end
		if (go_norm) begin
			nxt_st = ST_RX;
			nxt_rsp[1] = hdr_ff[1];
			nxt_rlen = RSP_NORM;
		end
		// Broadcasts never get a reply.
		if ((go_exc || go_norm) && !bcast) begin
			nxt_rsp[0] = hdr_ff[0];
			nxt_st = ST_TX;
			nxt_n = 9'h000;
		end
		// Outcome reported by the outer logic for its functions.
		if (i_ext_done) begin
			nxt_ls = (i_ext_fc == FC_READ) ? i_ext_start : 16'h0000;
			nxt_lc = (i_ext_fc == FC_READ) ? i_ext_count : 16'h0000;
		end
	end

	// State registers.
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			st_ff <= ST_RX; n_ff <= 9'h000; crc_ff <= CRC_INIT;
			hdr_ff <= '{default: 8'h00}; dat_ff <= '{default: 16'h0000};
			drop_ff <= 1'b0; idx_ff <= 7'h00; addr_ff <= 16'h0000;
			nok_ff <= 16'h0000; first_ff <= 16'h0000; bad_ff <= 1'b0;
			rsp_ff <= '{default: 8'h00}; rlen_ff <= 3'h0; ext_ff <= 1'b0;
			efc_ff <= 8'h00; ls_ff <= 16'h0000; lc_ff <= 16'h0000;
			tv_ff <= 1'b0; td_ff <= 8'h00; tl_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st; n_ff <= nxt_n; crc_ff <= nxt_crc;
			hdr_ff <= nxt_hdr; dat_ff <= nxt_dat;
			drop_ff <= nxt_drop; idx_ff <= nxt_idx; addr_ff <= nxt_addr;
			nok_ff <= nxt_nok; first_ff <= nxt_first; bad_ff <= nxt_bad;
			rsp_ff <= nxt_rsp; rlen_ff <= nxt_rlen; ext_ff <= nxt_ext;
			efc_ff <= nxt_efc; ls_ff <= nxt_ls; lc_ff <= nxt_lc;
			tv_ff <= nxt_tv; td_ff <= nxt_td; tl_ff <= nxt_tl;
		end
	end

	// Writes to missing registers are simply not strobed.
	assign o_wr_en       = (st_ff == ST_WR) && i_reg_ok;
	assign o_reg_addr    = addr_ff;
	assign o_reg_data    = dat_ff[idx_ff];
	assign o_ext_frame   = ext_ff;
	assign o_ext_fc      = efc_ff;
	assign o_log_start   = ls_ff;
	assign o_log_count   = lc_ff;
	assign lnk.s2m_valid = tv_ff;
	assign lnk.s2m_data  = td_ff;
	assign lnk.s2m_last  = tl_ff;

endmodule : mb_slave

// File: rtl/mb_master.sv
`timescale 1ns/1ps
// Master end: issues write-multiple and log queries and checks replies.
module mb_master
	import mb_pkg::*;
#(
	parameter int RESP_WAIT = 1000 // Cycles to wait for a reply.
) (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rstn,
	mb_link_if.master        lnk,
	input  wire logic        i_go,
	input  wire logic        i_log,
	input  wire logic [7:0]  i_slave,
	input  wire logic [15:0] i_start,
	input  wire logic [15:0] i_count,
	output logic      [6:0]  o_widx,
	input  wire logic [15:0] i_wdata,
	output logic             o_busy,
	output logic             o_done,
	output logic             o_ok,
	output logic             o_exc,
	output logic             o_timeout,
	output logic      [7:0]  o_code,
	output logic      [15:0] o_word_a,
	output logic      [15:0] o_word_b
);

	typedef enum logic [2:0] {
		MS_IDLE = 3'b001,
		MS_SEND = 3'b010,
		MS_WAIT = 3'b100
	} mst_t;

	mst_t        st_ff,  nxt_st;   // Main state.
	logic [8:0]  n_ff,   nxt_n;    // Byte index.
	logic [15:0] crc_ff, nxt_crc;  // Running CRC.
	logic [7:0]  sl_ff,  nxt_sl;   // Target slave.
	logic [15:0] sa_ff,  nxt_sa;   // Start address.
	logic [15:0] cn_ff,  nxt_cn;   // Register count.
	logic        lg_ff,  nxt_lg;   // Log query selected.
	logic [8:0]  bl_ff,  nxt_bl;   // Body length before CRC.
	logic [15:0] tm_ff,  nxt_tm;   // Reply timer.
	logic [7:0]  rb_ff   [6];      // Reply bytes.
	logic [7:0]  nxt_rb  [6];
	logic        tv_ff, nxt_tv, tl_ff, nxt_tl, dn_ff, nxt_dn, ok_ff, nxt_ok;
	logic        to_ff, nxt_to;
	logic [7:0]  td_ff,  nxt_td;   // Transmit byte.
	logic [7:0]  fc, bsel;
	logic [8:0]  doff, n_in;
	logic [15:0] crc_cur, crc_in;

	assign fc      = lg_ff ? FC_LOG : FC_WRN;
	assign doff    = n_ff - WRN_HDR;
	assign n_in    = n_ff + 9'h001;
	assign crc_cur = (n_ff == 9'h000) ? CRC_INIT : crc_ff;
	assign crc_in  = crc_step(crc_cur, lnk.s2m_data);
	assign o_widx  = doff[7:1];

	// Query byte for the current index.
	always_comb begin
		case (n_ff)
			9'h000: bsel = sl_ff;
			9'h001: bsel = fc;
			9'h002: bsel = sa_ff[15:8];
			9'h003: bsel = sa_ff[7:0];
			9'h004: bsel = cn_ff[15:8];
			9'h005: bsel = cn_ff[7:0];
			9'h006: bsel = {cn_ff[6:0], 1'b0}; // Byte count is twice the count.
			default: bsel = doff[0] ? i_wdata[7:0] : i_wdata[15:8];
		endcase
	end

	// Next-state logic for send and wait.
	always_comb begin
		nxt_st = st_ff; nxt_n = n_ff; nxt_crc = crc_ff; nxt_sl = sl_ff;
		nxt_sa = sa_ff; nxt_cn = cn_ff; nxt_lg = lg_ff; nxt_bl = bl_ff;
		nxt_tm = tm_ff; nxt_rb = rb_ff; nxt_tv = 1'b0; nxt_tl = 1'b0;
		nxt_td = td_ff; nxt_dn = 1'b0; nxt_ok = ok_ff; nxt_to = 1'b0;
		case (st_ff)
			MS_IDLE: begin
				if (i_go) begin
					// Bad counts and broadcast log queries are refused.
					if (i_log ? (i_slave == BCAST_ADDR)
						: (i_count == 16'h0000 || i_count > 16'(MAX_REGS))) begin
						nxt_dn = 1'b1;
						nxt_ok = 1'b0;
					end else begin
						nxt_st = MS_SEND; nxt_n = 9'h000; nxt_sl = i_slave;
						nxt_sa = i_start; nxt_cn = i_count; nxt_lg = i_log;
						nxt_bl = i_log ? LOG_BODY : WRN_HDR + {i_count[7:0], 1'b0};
					end
				end
			end
			MS_SEND: begin
				nxt_tv = 1'b1;
				nxt_n = n_in;
				if (n_ff < bl_ff) begin
					nxt_td = bsel;
					nxt_crc = crc_step(crc_cur, bsel);
				end else if (n_ff == bl_ff) begin
					nxt_td = crc_ff[7:0];
				end else begin
					nxt_td = crc_ff[15:8];
					nxt_tl = 1'b1;
					nxt_n = 9'h000;
					nxt_tm = 16'h0000;
					// A broadcast write expects no reply.
					if (sl_ff == BCAST_ADDR) begin
						nxt_st = MS_IDLE;
						nxt_dn = 1'b1;
						nxt_ok = 1'b1;
					end else begin
						nxt_st = MS_WAIT;
					end
				end
			end
			MS_WAIT: begin
				nxt_tm = tm_ff + 16'h0001;
				if (lnk.s2m_valid) begin
					nxt_crc = crc_in;
					nxt_n = n_in;
					if (n_ff < 9'(RSP_NORM)) begin
						nxt_rb[n_ff[2:0]] = lnk.s2m_data;
					end
					if (lnk.s2m_last) begin
						nxt_st = MS_IDLE;
						nxt_dn = 1'b1;
						nxt_ok = (crc_in == 16'h0000) && (n_in >= MIN_FRAME)
							&& (rb_ff[0] == sl_ff) && ((rb_ff[1] & ~EXC_FLAG) == fc);
					end
				end else if (tm_ff == 16'(RESP_WAIT)) begin
					nxt_st = MS_IDLE;
					nxt_dn = 1'b1;
					nxt_ok = 1'b0;
					nxt_to = 1'b1;
				end
			end
			default: begin
				nxt_st = MS_IDLE;
			end
		endcase
	end

	// State registers.
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			st_ff <= MS_IDLE; n_ff <= 9'h000; crc_ff <= CRC_INIT; sl_ff <= 8'h00;
			sa_ff <= 16'h0000; cn_ff <= 16'h0000; lg_ff <= 1'b0; bl_ff <= 9'h000;
			tm_ff <= 16'h0000; rb_ff <= '{default: 8'h00}; tv_ff <= 1'b0;
			tl_ff <= 1'b0; td_ff <= 8'h00; dn_ff <= 1'b0; ok_ff <= 1'b0; to_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st; n_ff <= nxt_n; crc_ff <= nxt_crc; sl_ff <= nxt_sl;
			sa_ff <= nxt_sa; cn_ff <= nxt_cn; lg_ff <= nxt_lg; bl_ff <= nxt_bl;
			tm_ff <= nxt_tm; rb_ff <= nxt_rb; tv_ff <= nxt_tv;
			tl_ff <= nxt_tl; td_ff <= nxt_td; dn_ff <= nxt_dn; ok_ff <= nxt_ok; to_ff <= nxt_to;
		end
	end

	assign o_busy        = (st_ff != MS_IDLE);
	assign o_done        = dn_ff;
	assign o_ok          = ok_ff;
	assign o_exc         = rb_ff[1][7];
	assign o_timeout     = to_ff;
	assign o_code        = rb_ff[2];
	assign o_word_a      = {rb_ff[2], rb_ff[3]};
	assign o_word_b      = {rb_ff[4], rb_ff[5]};
	assign lnk.m2s_valid = tv_ff;
	assign lnk.m2s_data  = td_ff;
	assign lnk.m2s_last  = tl_ff;
	assign lnk.m2s_err   = 1'b0;

endmodule : mb_master

// File: dv/mb_link_props.sv
`timescale 1ns/1ps
// Watches one link; every check is on the wire.
module mb_link_props
	import mb_pkg::*;
(
	input  wire logic       i_clk_sys, // System clock.
	input  wire logic       i_rstn,    // Reset, active low.
	input  wire logic       m2s_valid, // Query byte present.
	input  wire logic [7:0] m2s_data,  // Query byte.
	input  wire logic       m2s_last,  // Last query byte.
	input  wire logic       m2s_err,   // Line error flag.
	input  wire logic       s2m_valid, // Reply byte present.
	input  wire logic [7:0] s2m_data,  // Reply byte.
	input  wire logic       s2m_last   // Last reply byte.
);
	logic [8:0]  qcnt_ff; // Index of the next query byte.
	logic [7:0]  qadr_ff; // Slave address of the latest query.
	logic [7:0]  qfc_ff;  // Function of the latest query.
	logic [15:0] qcrc_ff; // Running CRC of the query so far.
	logic [3:0]  rcnt_ff; // Index of the next reply byte.
	logic [15:0] rcrc_ff; // Running CRC of the reply so far.

	// Folds one byte into a CRC; a whole frame with its CRC leaves zero.
	function automatic logic [15:0] crc_b(input logic [15:0] c, input logic [7:0] b);
		c = c ^ {8'h00, b};
		for (int k = 0; k < 8; k++) begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction : crc_b

	// Tracks position and CRC of the frames in both directions, and the header of the queries.
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			qcnt_ff <= 9'h000;
			qadr_ff <= 8'h00;
			qfc_ff  <= 8'h00;
			qcrc_ff <= CRC_INIT;
			rcnt_ff <= 4'h0;
			rcrc_ff <= CRC_INIT;
		end else begin
			// A query byte moves the index; the first two bytes are kept.
			if (m2s_valid) begin
				qcnt_ff <= m2s_last ? 9'h000 : qcnt_ff + 9'h001;
				qcrc_ff <= m2s_last ? CRC_INIT : crc_b(qcrc_ff, m2s_data);
				if (qcnt_ff == 9'h000) qadr_ff <= m2s_data;
				if (qcnt_ff == 9'h001) qfc_ff <= m2s_data;
			end
			// A reply byte moves the reply index and CRC.
			if (s2m_valid) begin
				rcnt_ff <= s2m_last ? 4'h0 : rcnt_ff + 4'h1;
				rcrc_ff <= s2m_last ? CRC_INIT : crc_b(rcrc_ff, s2m_data);
			end
		end
	end

	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);

	AST_TX_CRC: assert property (s2m_last |-> crc_b(rcrc_ff, s2m_data) == 16'h0000)
		else $error("reply CRC does not check");
	AST_RX_CRC: assert property (m2s_last |-> crc_b(qcrc_ff, m2s_data) == 16'h0000)
		else $error("query CRC does not check");
	AST_TX_LEN: assert property (s2m_last |-> rcnt_ff == 4'h7 || rcnt_ff == 4'h4)
		else $error("reply length wrong");
	AST_TX_ADDR: assert property (s2m_valid && rcnt_ff == 4'h0 |-> s2m_data == qadr_ff)
		else $error("reply address differs from query");
	AST_TX_FC: assert property (s2m_valid && rcnt_ff == 4'h1 |->
		s2m_data == qfc_ff || s2m_data == (qfc_ff | EXC_FLAG)) else $error("reply function wrong");
	AST_TX_B2B: assert property (s2m_valid && !s2m_last |=> s2m_valid)
		else $error("reply bytes not back to back");
	AST_RX_B2B: assert property (m2s_valid && !m2s_last |=> m2s_valid && !m2s_err)
		else $error("query bytes not back to back");
	AST_LOG_ANS: assert property (m2s_last && qfc_ff == FC_LOG && qadr_ff != BCAST_ADDR
		|-> ##2 s2m_valid) else $error("log reply late");
	AST_WR_ANS: assert property (m2s_last && qfc_ff == FC_WRN && qadr_ff != BCAST_ADDR
		|-> ##[2:260] s2m_valid) else $error("write reply missing");
	AST_BCAST_QUIET: assert property (m2s_last && qadr_ff == BCAST_ADDR
		|=> !s2m_valid [*8]) else $error("reply to broadcast");

endmodule : mb_link_props

// File: dv/mb_slave_tb.sv
`timescale 1ns/1ps
// Runs write, log and error traffic over two links.
module mb_slave_tb
	import mb_pkg::*;
;
	logic        i_clk_sys = 1'b0; // System clock.
	logic        i_rstn    = 1'b0; // Reset, active low.
	logic        go = 1'b0;        // Master request pulse.
	logic        lg = 1'b0;        // Request is a log query.
	logic [7:0]  sl = 8'h00;       // Target slave address.
	logic [15:0] st = 16'h0000;    // Start index.
	logic [15:0] cn = 16'h0000;    // Register count.
	logic [6:0]  widx;             // Word wanted by the master.
	logic [15:0] wd;               // Word handed to the master.
	logic        busy, done, ok, exc, tmo;
	logic [7:0]  code;             // Reply code byte.
	logic [15:0] wa, wb;           // Reply words.
	logic [15:0] wbuf [0:127];     // Words to write.
	logic [15:0] ra_adr, ra_dat, rb_adr, rb_dat, lst, lcn;
	logic        wr_a, wr_b, efrm;
	logic [7:0]  efc;              // Function handed outward by the second slave.
	logic        ext_done = 1'b0;  // Outer logic finished a transaction.
	logic [7:0]  ext_fc = 8'h00;
	logic [15:0] ext_st = 16'h0000;
	logic [15:0] ext_cn = 16'h0000;
	logic [7:0]  my_addr = 8'h19;  // Own address of both slaves.
	logic [15:0] mem [logic [15:0]]; // Registers as written.
	logic [7:0]  qa[$], ra[$], rb[$]; // Bytes seen on the wires.
	int          nfrm = 0;         // Frames handed outward and register writes of the second slave.
	int          errors = 0;
	int          cmp_count = 0;
	mb_link_if   la();
	mb_link_if   lb();

	// Register map: five places from 03ee, of which 03f0 is missing.
	function automatic logic reg_ok(input logic [15:0] a);
		return a >= 16'h03ee && a <= 16'h03f2 && a != 16'h03f0;
	endfunction : reg_ok

	// CRC over a byte stream; zero when the stream ends with its own CRC.
	function automatic logic [15:0] crc_q(input logic [7:0] q[$]);
		logic [15:0] c;
		c = CRC_INIT;
		foreach (q[i]) begin
			c = c ^ {8'h00, q[i]};
			for (int k = 0; k < 8; k++) begin
				c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
			end
		end
		return c;
	endfunction : crc_q

	assign wd = wbuf[widx];

	mb_master #(.RESP_WAIT(400)) i_mb_master (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .lnk(la),
		.i_go(go), .i_log(lg), .i_slave(sl), .i_start(st), .i_count(cn), .o_widx(widx),
		.i_wdata(wd), .o_busy(busy), .o_done(done), .o_ok(ok), .o_exc(exc), .o_timeout(tmo),
		.o_code(code), .o_word_a(wa), .o_word_b(wb));
	mb_slave i_mb_slave (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .lnk(la), .i_my_addr(my_addr),
		.o_reg_addr(ra_adr), .o_reg_data(ra_dat), .i_reg_ok(reg_ok(ra_adr)),
		.i_val_ok(ra_dat != 16'hffff), .o_wr_en(wr_a), .o_ext_frame(), .o_ext_fc(),
		.i_ext_done(ext_done), .i_ext_fc(ext_fc), .i_ext_start(ext_st), .i_ext_count(ext_cn),
		.o_log_start(lst), .o_log_count(lcn));
	mb_slave i_mb_slave_b (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .lnk(lb), .i_my_addr(my_addr),
		.o_reg_addr(rb_adr), .o_reg_data(rb_dat), .i_reg_ok(reg_ok(rb_adr)),
		.i_val_ok(rb_dat != 16'hffff), .o_wr_en(wr_b), .o_ext_frame(efrm), .o_ext_fc(efc),
		.i_ext_done(ext_done), .i_ext_fc(ext_fc), .i_ext_start(ext_st), .i_ext_count(ext_cn),
		.o_log_start(), .o_log_count());
	mb_link_props i_mb_link_props (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
		.m2s_valid(la.m2s_valid), .m2s_data(la.m2s_data), .m2s_last(la.m2s_last),
		.m2s_err(la.m2s_err), .s2m_valid(la.s2m_valid), .s2m_data(la.s2m_data),
		.s2m_last(la.s2m_last));

	always #12.5 i_clk_sys = ~i_clk_sys;

	// Records wire bytes and register writes mid-cycle.
	always @(negedge i_clk_sys) begin
		if (la.m2s_valid === 1'b1) qa.push_back(la.m2s_data);
		if (la.s2m_valid === 1'b1) ra.push_back(la.s2m_data);
		if (lb.s2m_valid === 1'b1) rb.push_back(lb.s2m_data);
		if (wr_a === 1'b1) mem[ra_adr] = ra_dat;
		if ((efrm | wr_b) === 1'b1) nfrm++;
	end

	// Compares one value and counts the outcome.
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	// Compares a captured byte stream with the expected stream.
	task automatic chkq(input logic [7:0] s[$], input logic [7:0] e[$]);
		chk(16'(s.size()), 16'(e.size()));
		foreach (e[i]) begin
			chk(16'(s[i]), 16'(e[i]));
		end
	endtask : chkq

	// Issues one master request and waits for its completion pulse.
	task automatic op(input logic l, input logic [7:0] s, input logic [15:0] a,
		input logic [15:0] n);
		int k;
		qa.delete();
		ra.delete();
		@(posedge i_clk_sys);
		go <= 1'b1;
		lg <= l;
		sl <= s;
		st <= a;
		cn <= n;
		@(posedge i_clk_sys);
		go <= 1'b0;
		k = 0;
		do begin
			@(negedge i_clk_sys);
			k++;
		end while (done !== 1'b1 && k < 600);
		if (k >= 600) errors++;
	endtask : op

	// Sends a frame on the second link with its CRC, optionally spoilt.
	task automatic send_b(input logic [7:0] q[$], input bit bad, input int ei);
		logic [15:0] c;
		c = crc_q(q);
		q.push_back(c[7:0] ^ {7'h00, bad});
		q.push_back(c[15:8]);
		rb.delete();
		foreach (q[i]) begin
			@(posedge i_clk_sys);
			lb.m2s_valid <= 1'b1;
			lb.m2s_data  <= q[i];
			lb.m2s_last  <= (i == q.size() - 1);
			lb.m2s_err   <= (i == ei);
		end
		@(posedge i_clk_sys);
		lb.m2s_valid <= 1'b0;
		lb.m2s_last  <= 1'b0;
		lb.m2s_err   <= 1'b0;
		lb.m2s_data  <= ~q[q.size() - 1];
		repeat (30) @(posedge i_clk_sys);
	endtask : send_b

	// Checks an exception reply captured on the second link.
	task automatic expb(input logic [7:0] f, input logic [7:0] e);
		chkq(rb[0:2], {my_addr, f, e});
		chk(crc_q(rb), 16'h0000);
	endtask : expb

	// Prints the verdict and ends the run.
	task automatic results;
		if (errors == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : results

	// Cuts a hung run short.
	initial begin
		repeat (20000) @(posedge i_clk_sys);
		errors++;
		results();
	end

	// Main sequence.
	initial begin
		lb.m2s_valid = 1'b0;
		lb.m2s_data  = 8'h00;
		lb.m2s_last  = 1'b0;
		lb.m2s_err   = 1'b0;
		for (int i = 0; i < 128; i++) begin
			wbuf[i] = 16'(i);
		end
		wbuf[0] = 16'h0005;
		wbuf[1] = 16'h000a;
		repeat (6) @(posedge i_clk_sys);
		i_rstn <= 1'b1;
		op(1'b0, 8'h19, 16'h03ee, 16'h0002);
		chkq(qa, {8'h19, 8'h10, 8'h03, 8'hee, 8'h00, 8'h02, 8'h04, 8'h00, 8'h05, 8'h00, 8'h0a,
			8'h86, 8'h3d});
		chkq(ra, {8'h19, 8'h10, 8'h03, 8'hee, 8'h00, 8'h02, 8'h22, 8'h61});
		chk(wa, 16'h03ee);
		chk(16'(ok), 16'h0001);
		chk(mem[16'h03ef], 16'h000a);
		op(1'b1, 8'h19, 16'h0000, 16'h0000);
		chkq(qa, {8'h19, 8'h46, 8'h8b, 8'hd2});
		chk(wa, 16'h03ee);
		chk(wb, 16'h0002);
		wbuf[0] = 16'h0000;
		op(1'b0, 8'h19, 16'h03ee, 16'd125);
		chk({lcn[7:0], 7'h0, ok}, 16'h0401);
		chk(mem[16'h03f2], 16'h0004);
		op(1'b0, 8'h19, 16'h03ed, 16'h0003);
		chk({lst[11:0], 3'h0, ok}, 16'h3ee1);
		chk(16'(mem.exists(16'h03ed)), 16'h0000);
		op(1'b0, 8'h19, 16'h0100, 16'h0002);
		chk({6'h0, tmo, exc, code}, 16'h0102);
		wbuf[1] = 16'hffff;
		op(1'b0, 8'h19, 16'h03ee, 16'h0002);
		chk({6'h0, tmo, exc, code}, 16'h0103);
		op(1'b0, 8'h19, 16'h03ee, 16'd126);
		chk(16'({ok, busy, tmo, qa.size() == 0}), 16'h0001);
		op(1'b1, BCAST_ADDR, 16'h0000, 16'h0000);
		chk(16'({ok, qa.size() == 0}), 16'h0001);
		wbuf[0] = 16'h0077;
		op(1'b0, BCAST_ADDR, 16'h03f1, 16'h0001);
		repeat (10) @(posedge i_clk_sys);
		chk(mem[16'h03f1], 16'h0077);
		chk(16'(ra.size()), 16'h0000);
		@(posedge i_clk_sys);
		ext_done <= 1'b1;
		ext_fc   <= FC_READ;
		ext_st   <= 16'h0007;
		ext_cn   <= 16'h0003;
		@(posedge i_clk_sys);
		ext_done <= 1'b0;
		op(1'b1, 8'h19, 16'h0000, 16'h0000);
		chk({wa[7:0], wb[7:0]}, 16'h0703);
		@(posedge i_clk_sys);
		ext_done <= 1'b1;
		ext_fc   <= FC_WR1;
		@(posedge i_clk_sys);
		ext_done <= 1'b0;
		@(negedge i_clk_sys);
		chk(lst | lcn, 16'h0000);
		send_b({8'h19, 8'h41}, 1'b0, -1);
		expb(8'hc1, EXC_FUNC);
		send_b({8'h19, FC_WRN, 8'h03, 8'hee, 8'h00, 8'h02, 8'h03, 8'h00, 8'h05, 8'h00}, 1'b0, -1);
		expb(8'h90, EXC_DATA);
		send_b({8'h19, FC_READ, 8'h03, 8'hee, 8'h00, 8'h01}, 1'b0, -1);
		chk({efc, 8'(nfrm + rb.size())}, 16'h0301);
		send_b({8'h19, 8'h41}, 1'b1, -1);
		chk(16'(rb.size()), 16'h0000);
		send_b({8'h19, 8'h41}, 1'b0, 1);
		chk(16'(rb.size()), 16'h0000);
		send_b({8'h19}, 1'b0, -1);
		chk(16'(rb.size()), 16'h0000);
		send_b({BCAST_ADDR, 8'h41}, 1'b0, -1);
		chk(16'(rb.size()), 16'h0000);
		send_b({BCAST_ADDR, FC_LOG}, 1'b0, -1);
		chk(16'(rb.size()), 16'h0000);
		results();
	end

endmodule : mb_slave_tb
